// *** rtl/eid_pkg.sv ***
package eid_pkg;
  // Register word byte offsets
  localparam logic [7:0] ADR_CMD  = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_AF   = 8'h08;
  localparam logic [7:0] ADR_BC   = 8'h0c;
  localparam logic [7:0] ADR_DE   = 8'h10;
  localparam logic [7:0] ADR_HL   = 8'h14;
  localparam logic [7:0] ADR_STK  = 8'h18;
  localparam logic [7:0] ADR_PCNT = 8'h1c;
  localparam logic [7:0] ADR_IX   = 8'h20;
  localparam logic [7:0] ADR_IY   = 8'h24;
  localparam logic [7:0] ADR_IR   = 8'h28;
  localparam logic [7:0] ADR_XCHG = 8'h2c;
  // Command word fields
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_SEL_LSB = 4;
  localparam int CMD_IMM_LSB = 8;
  // Exchange word bits
  localparam int XCH_AF  = 0;
  localparam int XCH_GEN = 1;
  // Status word bits
  localparam int STA_BUSY  = 8;
  localparam int STA_SLEEP = 9;
  // Flag bit positions
  localparam int FLG_S  = 7;
  localparam int FLG_Z  = 6;
  localparam int FLG_H  = 4;
  localparam int FLG_PV = 2;
  localparam int FLG_N  = 1;
  localparam int FLG_C  = 0;
  // Reset values and upper I/O address byte
  localparam logic [15:0] REG16_RST = 16'h0000;
  localparam logic [7:0]  REG8_RST  = 8'h00;
  localparam logic [7:0]  IO_HIGH   = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_MEM_RD = 3'b001,
    ST_IO_RD  = 3'b010,
    ST_IO_WR  = 3'b011,
    ST_SLEEP  = 3'b100
  } eid_state_t;

  typedef enum logic [3:0] {
    OP_NONE        = 4'h0,
    OP_MULT        = 4'h1,
    OP_IN_SHORT    = 4'h2,
    OP_OUT_SHORT   = 4'h3,
    OP_BLK_INC     = 4'h4,
    OP_BLK_INC_RPT = 4'h5,
    OP_BLK_DEC     = 4'h6,
    OP_BLK_DEC_RPT = 4'h7,
    OP_TEST_IO     = 4'h8,
    OP_TEST_REG    = 4'h9,
    OP_TEST_IMM    = 4'ha,
    OP_TEST_MEM    = 4'hb,
    OP_SLEEP       = 4'hc
  } eid_op_t;

  typedef struct packed {
    logic        req;
    logic        isIo;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } eid_xreq_t;

  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
  } eid_xrsp_t;

  typedef struct packed {
    logic [7:0]  a;
    logic [7:0]  f;
    logic [15:0] bc;
    logic [15:0] de;
    logic [15:0] hl;
    logic [15:0] altAf;
    logic [15:0] altBc;
    logic [15:0] altDe;
    logic [15:0] altHl;
    logic [7:0]  ivec;
    logic [7:0]  rcnt;
    logic [15:0] ix;
    logic [15:0] iy;
    logic [15:0] stackPtr;
    logic [15:0] progCnt;
  } eid_regs_t;

  typedef struct packed {
    eid_state_t state;
    eid_op_t    op;
    logic [2:0] sel;
    logic [7:0] imm;
    logic [7:0] data;
    eid_regs_t  rg;
    eid_xreq_t  bus;
    logic [31:0] wbDat;
  } eid_core_t;

  typedef struct packed {
    logic ack;
  } eid_wbst_t;
endpackage : eid_pkg

// *** rtl/eid_wb_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module eid_wb_port
  import eid_pkg::*;
(
  input  wire logic core_clk,  // System clock
  input  wire logic rst_n,     // Async reset, low
  input  wire logic cyc,       // Bus cycle
  input  wire logic stb,       // Strobe
  input  wire logic we,        // Write enable
  output logic      ack,       // Registered acknowledge
  output logic      wrStb,     // Accepted write pulse
  output logic      rdStb      // Accepted read pulse
);
  eid_wbst_t s, n;

  // Accept once per request, ack one cycle later
  always_comb begin
    n = s;
    n.ack = cyc && stb && !s.ack;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign ack   = s.ack;
  assign wrStb = cyc && stb && !s.ack && we;
  assign rdStb = cyc && stb && !s.ack && !we;
endmodule : eid_wb_port
`default_nettype wire

// *** rtl/eid_logic_flags.sv ***
`timescale 1ns/1ps
`default_nettype none
module eid_logic_flags
  import eid_pkg::*;
(
  input  wire logic [7:0] val,    // Logical result
  output logic      [7:0] flags   // Resulting flag byte
);
  // Flag byte for a logical AND result
  always_comb begin
    flags         = 8'h00;
    flags[FLG_S]  = val[7];
    flags[FLG_Z]  = (val == 8'h00);
    flags[FLG_H]  = 1'b1;
    flags[FLG_PV] = ~^val;
    flags[FLG_N]  = 1'b0;
    flags[FLG_C]  = 1'b0;
  end
endmodule : eid_logic_flags
`default_nettype wire

// *** rtl/eid_datapath.sv ***
// Contract
// RULE_01 - multiply pair halves unsigned, 16-bit product back into that pair
// RULE_02 - multiply may select BC, DE, HL or stack pointer
// RULE_03 - short input reads I/O at immediate address into register
// RULE_04 - short output writes register to I/O at immediate address
// RULE_05 - upper I/O address byte is 00 for short, block and port test
// RULE_06 - block output moves byte at HL to I/O address in C
// RULE_07 - increment variants bump HL and C, decrement variants lower both
// RULE_08 - each step decrements B; repeat variants loop until B is zero
// RULE_09 - port test ANDs port at C with immediate, flags only
// RULE_10 - register test ANDs register with A, flags only
// RULE_11 - immediate test ANDs immediate with A, A kept
// RULE_12 - memory test ANDs byte at HL with A, nothing written
// RULE_13 - sleep instruction enters low-power sleep state
// RULE_14 - main set holds A, F, BC, DE, HL as pairs or bytes
// RULE_15 - alternate set not addressable, swapped by exchange
// RULE_16 - special: vector base, refresh counter, two index, stack, program counter
// RULE_17 - flag layout S7 Z6 H4 PV2 N1 C0, sign copies bit 7
// RULE_18 - logical results: Z when zero, PV set for even parity
// RULE_19 - low seven refresh counter bits count opcode fetches
// RULE_20 - multiply keeps flags and all other registers
`timescale 1ns/1ps
`default_nettype none
module eid_datapath
  import eid_pkg::*;
(
  input  wire logic        core_clk,    // System clock
  input  wire logic        rst_n,       // Async reset, low
  input  wire logic        wb_cyc_i,    // Wishbone cycle
  input  wire logic        wb_stb_i,    // Wishbone strobe
  input  wire logic        wb_we_i,     // Wishbone write
  input  wire logic [7:0]  wb_adr_i,    // Byte address
  input  wire logic [3:0]  wb_sel_i,    // Byte enables
  input  wire logic [31:0] wb_dat_i,    // Write data
  output logic      [31:0] wb_dat_o,    // Read data
  output logic             wb_ack_o,    // Acknowledge
  output eid_xreq_t        xbusReq,     // External bus request
  input  wire eid_xrsp_t   xbusRsp,     // External bus answer
  input  wire logic        fetchPulse,  // Opcode fetch cycle
  input  wire logic        wakeReq,     // Leave sleep
  output logic             sleepMode    // Sleep state
);
  eid_core_t  s, n;
  logic       wrStb, rdStb, busy, cmdGo, blkOp, stepDone, flagLoad;
  logic [7:0] andVal, logicFlags;
  eid_op_t    cmdOp;
  logic [2:0] cmdSel;
  logic [7:0] cmdImm;

  eid_wb_port u_wb (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .cyc      (wb_cyc_i),
    .stb      (wb_stb_i),
    .we       (wb_we_i),
    .ack      (wb_ack_o),
    .wrStb    (wrStb),
    .rdStb    (rdStb)
  );

  // RULE_17 flag bit layout
  eid_logic_flags u_flags (
    .val   (andVal),
    .flags (logicFlags)
  );

  // RULE_14 byte view of pairs
  function automatic logic [7:0] getReg8(input eid_regs_t r, input logic [2:0] g);
    case (g)
      3'h0:    return r.bc[15:8];
      3'h1:    return r.bc[7:0];
      3'h2:    return r.de[15:8];
      3'h3:    return r.de[7:0];
      3'h4:    return r.hl[15:8];
      3'h5:    return r.hl[7:0];
      3'h7:    return r.a;
      default: return 8'h00;
    endcase
  endfunction : getReg8

  function automatic eid_regs_t setReg8(input eid_regs_t r, input logic [2:0] g,
                                        input logic [7:0] v);
    eid_regs_t t;
    t = r;
    case (g)
      3'h0:    t.bc[15:8] = v;
      3'h1:    t.bc[7:0] = v;
      3'h2:    t.de[15:8] = v;
      3'h3:    t.de[7:0] = v;
      3'h4:    t.hl[15:8] = v;
      3'h5:    t.hl[7:0] = v;
      3'h7:    t.a = v;
      default: t = r;
    endcase
    return t;
  endfunction : setReg8

  // RULE_02 pair selection for multiply
  function automatic eid_regs_t mulPair(input eid_regs_t r, input logic [1:0] w);
    eid_regs_t t;
    t = r;
    case (w)
      2'h0:    t.bc = 16'(r.bc[15:8]) * 16'(r.bc[7:0]);
      2'h1:    t.de = 16'(r.de[15:8]) * 16'(r.de[7:0]);
      2'h2:    t.hl = 16'(r.hl[15:8]) * 16'(r.hl[7:0]);
      default: t.stackPtr = 16'(r.stackPtr[15:8]) * 16'(r.stackPtr[7:0]);
    endcase
    return t;
  endfunction : mulPair

  function automatic logic [15:0] merge16(input logic [15:0] o, input logic [15:0] v,
                                          input logic [1:0] be);
    return {be[1] ? v[15:8] : o[15:8], be[0] ? v[7:0] : o[7:0]};
  endfunction : merge16

  // Command decode and status terms
  assign cmdOp    = eid_op_t'(wb_dat_i[CMD_OP_LSB +: 4]);
  assign cmdSel   = wb_dat_i[CMD_SEL_LSB +: 3];
  assign cmdImm   = wb_dat_i[CMD_IMM_LSB +: 8];
  assign busy     = (s.state != ST_IDLE);
  assign cmdGo    = wrStb && !busy && (wb_adr_i == ADR_CMD) && (cmdOp != OP_NONE);
  assign blkOp    = (s.op >= OP_BLK_INC) && (s.op <= OP_BLK_DEC_RPT);
  assign stepDone = (s.state == ST_IO_WR) && xbusRsp.ack && blkOp;

  // RULE_09 RULE_10 RULE_11 RULE_12 AND operand select
  assign andVal = (s.state == ST_IDLE) ?
                  (s.rg.a & ((cmdOp == OP_TEST_IMM) ? cmdImm : getReg8(s.rg, cmdSel))) :
                  (xbusRsp.rdata & ((s.op == OP_TEST_IO) ? s.imm : s.rg.a));
  assign flagLoad = (cmdGo && (cmdOp == OP_TEST_REG || cmdOp == OP_TEST_IMM)) ||
                    (xbusRsp.ack && s.state == ST_MEM_RD && s.op == OP_TEST_MEM) ||
                    (xbusRsp.ack && s.state == ST_IO_RD && s.op == OP_TEST_IO);

  // Next-state logic for the whole block
  always_comb begin
    n = s;
    // RULE_19 refresh count per fetch
    if (fetchPulse) begin
      n.rg.rcnt = {s.rg.rcnt[7], 7'(s.rg.rcnt[6:0] + 7'h01)};
    end
    // Register reads, unmapped reads give zero
    if (rdStb) begin
      case (wb_adr_i)
        ADR_STAT: n.wbDat = {22'h0, sleepMode, busy, s.rg.f};
        ADR_AF:   n.wbDat = {16'h0, s.rg.a, s.rg.f};
        ADR_BC:   n.wbDat = {16'h0, s.rg.bc};
        ADR_DE:   n.wbDat = {16'h0, s.rg.de};
        ADR_HL:   n.wbDat = {16'h0, s.rg.hl};
        ADR_STK:  n.wbDat = {16'h0, s.rg.stackPtr};
        ADR_PCNT: n.wbDat = {16'h0, s.rg.progCnt};
        ADR_IX:   n.wbDat = {16'h0, s.rg.ix};
        ADR_IY:   n.wbDat = {16'h0, s.rg.iy};
        ADR_IR:   n.wbDat = {16'h0, s.rg.ivec, s.rg.rcnt};
        default:  n.wbDat = 32'h0;
      endcase
    end
    // Register writes while idle
    if (wrStb && !busy) begin
      case (wb_adr_i)
        ADR_AF:   {n.rg.a, n.rg.f} = merge16({s.rg.a, s.rg.f}, wb_dat_i[15:0], wb_sel_i[1:0]);
        ADR_BC:   n.rg.bc = merge16(s.rg.bc, wb_dat_i[15:0], wb_sel_i[1:0]);
        ADR_DE:   n.rg.de = merge16(s.rg.de, wb_dat_i[15:0], wb_sel_i[1:0]);
        ADR_HL:   n.rg.hl = merge16(s.rg.hl, wb_dat_i[15:0], wb_sel_i[1:0]);
        ADR_STK:  n.rg.stackPtr = merge16(s.rg.stackPtr, wb_dat_i[15:0], wb_sel_i[1:0]);
        ADR_PCNT: n.rg.progCnt = merge16(s.rg.progCnt, wb_dat_i[15:0], wb_sel_i[1:0]);
        ADR_IX:   n.rg.ix = merge16(s.rg.ix, wb_dat_i[15:0], wb_sel_i[1:0]);
        ADR_IY:   n.rg.iy = merge16(s.rg.iy, wb_dat_i[15:0], wb_sel_i[1:0]);
        ADR_IR:   {n.rg.ivec, n.rg.rcnt} = merge16({s.rg.ivec, n.rg.rcnt}, wb_dat_i[15:0],
                                                   wb_sel_i[1:0]);
        ADR_XCHG: begin
          // RULE_15 swap with alternate set
          if (wb_sel_i[0] && wb_dat_i[XCH_AF]) begin
            {n.rg.a, n.rg.f} = s.rg.altAf;
            n.rg.altAf = {s.rg.a, s.rg.f};
          end
          if (wb_sel_i[0] && wb_dat_i[XCH_GEN]) begin
            {n.rg.bc, n.rg.de, n.rg.hl} = {s.rg.altBc, s.rg.altDe, s.rg.altHl};
            {n.rg.altBc, n.rg.altDe, n.rg.altHl} = {s.rg.bc, s.rg.de, s.rg.hl};
          end
        end
        default: n.wbDat = n.wbDat;
      endcase
    end
    // RULE_17 RULE_18 logical flag update
    if (flagLoad) begin
      n.rg.f = logicFlags;
    end
    case (s.state)
      ST_IDLE: begin
        if (cmdGo) begin
          n.op  = cmdOp;
          n.sel = cmdSel;
          n.imm = cmdImm;
          case (cmdOp)
            // RULE_01 RULE_20 multiply in place
            OP_MULT: n.rg = mulPair(n.rg, cmdSel[1:0]);
            // RULE_03 RULE_05 short input
            OP_IN_SHORT: begin
              n.bus   = '{1'b1, 1'b1, 1'b0, {IO_HIGH, cmdImm}, 8'h00};
              n.state = ST_IO_RD;
            end
            // RULE_04 RULE_05 short output
            OP_OUT_SHORT: begin
              n.bus   = '{1'b1, 1'b1, 1'b1, {IO_HIGH, cmdImm}, getReg8(s.rg, cmdSel)};
              n.state = ST_IO_WR;
            end
            // RULE_09 port read at C
            OP_TEST_IO: begin
              n.bus   = '{1'b1, 1'b1, 1'b0, {IO_HIGH, s.rg.bc[7:0]}, 8'h00};
              n.state = ST_IO_RD;
            end
            OP_BLK_INC, OP_BLK_INC_RPT, OP_BLK_DEC, OP_BLK_DEC_RPT, OP_TEST_MEM: begin
              n.bus   = '{1'b1, 1'b0, 1'b0, s.rg.hl, 8'h00};
              n.state = ST_MEM_RD;
            end
            // RULE_13 enter sleep
            OP_SLEEP: n.state = ST_SLEEP;
            default: n.state = ST_IDLE;
          endcase
        end
      end
      ST_MEM_RD: begin
        if (xbusRsp.ack) begin
          n.data = xbusRsp.rdata;
          if (s.op == OP_TEST_MEM) begin
            n.bus.req = 1'b0;
            n.state   = ST_IDLE;
          end else begin
            // RULE_06 byte at HL to port C
            n.bus   = '{1'b1, 1'b1, 1'b1, {IO_HIGH, s.rg.bc[7:0]}, xbusRsp.rdata};
            n.state = ST_IO_WR;
          end
        end
      end
      ST_IO_RD: begin
        if (xbusRsp.ack) begin
          if (s.op == OP_IN_SHORT) begin
            n.rg = setReg8(n.rg, s.sel, xbusRsp.rdata);
          end
          n.bus.req = 1'b0;
          n.state   = ST_IDLE;
        end
      end
      ST_IO_WR: begin
        if (xbusRsp.ack) begin
          n.bus.req = 1'b0;
          n.state   = ST_IDLE;
          if (blkOp) begin
            // RULE_07 step pointers
            if (s.op == OP_BLK_INC || s.op == OP_BLK_INC_RPT) begin
              n.rg.hl = s.rg.hl + 16'h0001;
              n.rg.bc[7:0] = s.rg.bc[7:0] + 8'h01;
            end else begin
              n.rg.hl = s.rg.hl - 16'h0001;
              n.rg.bc[7:0] = s.rg.bc[7:0] - 8'h01;
            end
            // RULE_08 count down and repeat
            n.rg.bc[15:8] = s.rg.bc[15:8] - 8'h01;
            n.rg.f[FLG_Z] = (s.rg.bc[15:8] == 8'h01);
            n.rg.f[FLG_N] = s.data[7];
            if ((s.op == OP_BLK_INC_RPT || s.op == OP_BLK_DEC_RPT) &&
                (s.rg.bc[15:8] != 8'h01)) begin
              n.bus   = '{1'b1, 1'b0, 1'b0, n.rg.hl, 8'h00};
              n.state = ST_MEM_RD;
            end
          end
        end
      end
      ST_SLEEP: begin
        if (wakeReq) begin
          n.state = ST_IDLE;
        end
      end
      default: n.state = ST_IDLE;
    endcase
  end

  // State register
  // RULE_16 special registers held
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign wb_dat_o  = s.wbDat;
  assign xbusReq   = s.bus;
  assign sleepMode = (s.state == ST_SLEEP);

  // RULE_01 product check
  mult_product_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_01
    (cmdGo && cmdOp == OP_MULT && cmdSel[1:0] == 2'h0) |=>
      s.rg.bc == 16'($past(s.rg.bc[15:8])) * 16'($past(s.rg.bc[7:0])))
    else $error("multiply product wrong");

  // RULE_20 multiply side effects
  mult_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_20
    (cmdGo && cmdOp == OP_MULT && cmdSel[1:0] == 2'h3) |=>
      {s.rg.a, s.rg.f, s.rg.bc, s.rg.de, s.rg.hl} ==
      $past({s.rg.a, s.rg.f, s.rg.bc, s.rg.de, s.rg.hl}))
    else $error("multiply touched other state");

  // RULE_05 upper I/O byte
  io_high_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_05
    (xbusReq.req && xbusReq.isIo) |-> xbusReq.addr[15:8] == 8'h00)
    else $error("upper I/O address not zero");

  // RULE_06 block source and target
  blk_route_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_06
    (s.state == ST_MEM_RD && blkOp && xbusRsp.ack) |=>
      xbusReq.isIo && xbusReq.wr && xbusReq.addr[7:0] == s.rg.bc[7:0] &&
      xbusReq.wdata == $past(xbusRsp.rdata))
    else $error("block byte misrouted");

  // RULE_07 increment step
  blk_step_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_07
    (stepDone && s.op == OP_BLK_INC) |=>
      s.rg.hl == $past(s.rg.hl) + 16'h0001 &&
      s.rg.bc[7:0] == $past(s.rg.bc[7:0]) + 8'h01)
    else $error("block step pointers wrong");

  // RULE_08 repeat ends at zero
  blk_stop_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_08
    (stepDone && s.rg.bc[15:8] == 8'h01) |=> s.state == ST_IDLE && s.rg.bc[15:8] == 8'h00)
    else $error("block repeat did not stop");

  // RULE_10 operands kept
  test_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_10
    (cmdGo && cmdOp == OP_TEST_REG) |=>
      {s.rg.a, s.rg.bc, s.rg.de, s.rg.hl} == $past({s.rg.a, s.rg.bc, s.rg.de, s.rg.hl}))
    else $error("register test modified operand");

  // RULE_18 zero and parity
  and_flags_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_18
    flagLoad |=> s.rg.f[FLG_Z] == ($past(andVal) == 8'h00) &&
      s.rg.f[FLG_PV] == ~^$past(andVal) && s.rg.f[FLG_S] == $past(andVal[7]))
    else $error("logical flags wrong");

  // RULE_13 sleep entry
  sleep_entry_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_13
    (cmdGo && cmdOp == OP_SLEEP) |=> sleepMode)
    else $error("sleep not entered");

  // RULE_19 refresh counting
  refresh_count_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_19
    (fetchPulse && !(wrStb && wb_adr_i == ADR_IR)) |=>
      s.rg.rcnt[6:0] == $past(s.rg.rcnt[6:0]) + 7'h01 &&
      s.rg.rcnt[7] == $past(s.rg.rcnt[7]))
    else $error("refresh counter step wrong");
endmodule : eid_datapath
`default_nettype wire

// *** sim/eid_ext_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module eid_ext_model
  import eid_pkg::*;
(
  input  wire logic       core_clk, // System clock
  input  wire logic       rst_n,    // Async reset, low
  input  wire eid_xreq_t  req,      // Request from datapath
  input  wire logic [1:0] lat,      // Idle cycles before answer
  output eid_xrsp_t       rsp,      // Answer to datapath
  output logic            hiBad,    // Nonzero upper I/O byte seen
  output var int          wrCnt     // Writes taken
);
  logic [7:0] mem [256];
  logic [7:0] io  [256];
  logic [1:0] cnt;

  // Answer after lat cycles; the cycle after ack still shows the old request
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp   <= '0;
      cnt   <= 2'h0;
      hiBad <= 1'b0;
      wrCnt <= 0;
    end else if (rsp.ack) begin
      rsp.ack   <= 1'b0;
      rsp.rdata <= ~rsp.rdata;  // Released data does not hold
      cnt       <= 2'h0;
    end else if (req.req && cnt == lat) begin
      rsp.ack <= 1'b1;
      rsp.rdata <= req.isIo ? io[req.addr[7:0]] : mem[req.addr[7:0]];
      if (req.isIo && req.addr[15:8] != 8'h00) hiBad <= 1'b1;
      if (req.wr) begin
        wrCnt <= wrCnt + 1;
        if (req.isIo) io[req.addr[7:0]] <= req.wdata;
        else mem[req.addr[7:0]] <= req.wdata;
      end
    end else if (req.req) begin
      cnt <= cnt + 2'h1;
    end else begin
      rsp.rdata <= ~rsp.rdata;  // Toggles while idle
    end
  end
endmodule : eid_ext_model
`default_nettype wire

// *** sim/tb_extended_instruction_datapath.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_extended_instruction_datapath
  import eid_pkg::*;
;
  logic        core_clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
  logic        fetchPulse = 0, wakeReq = 0, ack, sleepMode, hiBad;
  logic [7:0]  adr = 8'h00, c0, mi, r [8];
  logic [31:0] dat = 32'h0, dato, rd, v;
  logic [63:0] note;
  logic [1:0]  lat = 2'h0;
  logic [7:0]  ra [10] = '{ADR_AF, ADR_BC, ADR_DE, ADR_HL, ADR_STK, ADR_PCNT, ADR_IX,
                            ADR_IY, ADR_IR, 8'h30};
  eid_xreq_t   xreq;
  eid_xrsp_t   xrsp;
  int          wrCnt, errors = 0, checked = 0, seed = 52542, n, st, d;
  logic [63:0] notes [$];
  string       what [$], nm;

  always #20 core_clk = ~core_clk;

  eid_datapath u_eid_datapath (
    .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack),
    .xbusReq(xreq), .xbusRsp(xrsp), .fetchPulse(fetchPulse), .wakeReq(wakeReq),
    .sleepMode(sleepMode));

  eid_ext_model u_eid_ext_model (
    .core_clk(core_clk), .rst_n(rst_n), .req(xreq), .lat(lat), .rsp(xrsp),
    .hiBad(hiBad), .wrCnt(wrCnt));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask : cmp

  // Compare every acked cycle that carries a mask against its note
  always @(posedge core_clk) if (ack === 1'b1 && notes.size() > 0) begin
    note = notes.pop_front();
    nm = what.pop_front();
    if (note[63:32] != 32'h0) cmp(nm, note[31:0] & note[63:32], dato & note[63:32]);
  end

  // One classic cycle, held until ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dd,
                     input logic [31:0] m, input string s);
    int k;
    k = 0;
    notes.push_back({m, dd});
    what.push_back(s);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= dd;
    do begin @(posedge core_clk); k++; end while (ack !== 1'b1 && k < 64);
    rd = dato;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (k >= 64) begin errors++; give_verdict(); end
    @(posedge core_clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] dd);
    bus(1'b1, a, dd, 32'h0, "");
  endtask : wr

  task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string s);
    bus(1'b0, a, e, m, s);
  endtask : chk

  task automatic cmd(input logic [3:0] op, input logic [2:0] s, input logic [7:0] m);
    int k;
    k = 0;
    wr(ADR_CMD, {16'h0, m, 1'b0, s, op});
    do begin bus(1'b0, ADR_STAT, 32'h0, 32'h0, ""); k++; end
      while (rd[STA_BUSY] !== 1'b0 && k < 600);
    if (k >= 600) begin errors++; give_verdict(); end
  endtask : cmd

  // Byte registers in and out of the word registers
  task automatic setAll;
    wr(ADR_BC, {r[0], r[1]}); wr(ADR_DE, {r[2], r[3]});
    wr(ADR_HL, {r[4], r[5]}); wr(ADR_AF, {r[7], 8'h00});
  endtask : setAll

  task automatic chkAll(input string s);
    chk(ADR_BC, 32'hffff, {r[0], r[1]}, s); chk(ADR_DE, 32'hffff, {r[2], r[3]}, s);
    chk(ADR_HL, 32'hffff, {r[4], r[5]}, s); chk(ADR_AF, 32'hff00, {r[7], 8'h00}, s);
  endtask : chkAll

  function automatic logic [7:0] lf(input logic [7:0] x);
    return {x[7], x == 8'h00, 1'b0, 1'b1, 1'b0, ~^x, 2'b00};
  endfunction : lf

  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 10; i++) chk(ra[i], 32'hffff, 32'h0, "reset");
    for (int i = 4; i < 9; i++) begin
      v = $random(seed);
      wr(ra[i], v);
      chk(ra[i], 32'hffff, v[15:0], "special");
    end
    $display("done reset");
    for (int w = 0; w < 4; w++) begin
      v = $random(seed);
      lat <= v[17:16];
      wr(ADR_AF, v[31:16]);
      wr(ra[1+w], v[15:0]);
      cmd(OP_MULT, w[2:0], 8'h00);
      chk(ra[1+w], 32'hffff, v[15:8] * v[7:0], "product");
      chk(ADR_AF, 32'hffd7, v[31:16], "mult flags");
    end
    $display("done multiply");
    for (int g = 0; g < 8; g++) if (g != 6) begin
      for (int i = 0; i < 8; i++) r[i] = $random(seed);
      setAll();
      v = $random(seed);
      lat <= v[9:8];
      cmd(OP_OUT_SHORT, g[2:0], v[7:0]);
      cmp("out data", r[g], u_eid_ext_model.io[v[7:0]]);
      u_eid_ext_model.io[v[23:16]] = v[31:24];
      cmd(OP_IN_SHORT, g[2:0], v[23:16]);
      r[g] = v[31:24];
      chkAll("in reg");
    end
    $display("done short io");
    for (int op = 4; op < 8; op++) begin
      v = $random(seed);
      c0 = v[7:0];
      d = op[1] ? -1 : 1;
      st = op[0] ? 3 : 1;
      for (int i = 0; i < 4; i++) u_eid_ext_model.mem[8'h80 + d * i] = v[15:8] + i;
      lat <= op[1:0];
      wr(ADR_HL, 32'h0080);
      wr(ADR_BC, {op[0] ? 8'h03 : 8'h02, c0});
      cmd(op[3:0], 3'h0, 8'h00);
      for (int i = 0; i < st; i++) begin
        mi = c0 + d * i;
        cmp("blk io", 8'(v[15:8] + i), u_eid_ext_model.io[mi]);
      end
      mi = c0 + d * st;
      chk(ADR_HL, 32'hffff, 16'h0080 + d * st, "blk hl");
      chk(ADR_BC, 32'hff00, {op[0] ? 8'h00 : 8'h01, 8'h00}, "blk count");
      chk(ADR_BC, 32'h00ff, mi, "blk port");
    end
    $display("done block");
    for (int i = 0; i < 8; i++) r[i] = $random(seed);
    setAll();
    v = $random(seed);
    n = wrCnt;
    cmd(OP_TEST_REG, 3'h0, 8'h00);
    chk(ADR_AF, 32'hffd7, {r[7], lf(r[7] & r[0])}, "tst reg");
    chk(ADR_BC, 32'hffff, {r[0], r[1]}, "tst reg b");
    cmd(OP_TEST_IMM, 3'h0, v[7:0]);
    chk(ADR_AF, 32'hffd7, {r[7], lf(r[7] & v[7:0])}, "tst imm");
    cmd(OP_TEST_IMM, 3'h0, 8'h00);
    chk(ADR_AF, 32'hffd7, {r[7], 8'h54}, "tst zero");
    u_eid_ext_model.mem[r[5]] = v[15:8];
    cmd(OP_TEST_MEM, 3'h0, 8'h00);
    chk(ADR_AF, 32'hffd7, {r[7], lf(r[7] & v[15:8])}, "tst mem");
    u_eid_ext_model.io[r[1]] = v[23:16];
    cmd(OP_TEST_IO, 3'h0, v[31:24]);
    chk(ADR_AF, 32'hffd7, {r[7], lf(v[23:16] & v[31:24])}, "tst io");
    cmp("no writes", n, wrCnt);
    cmp("io high", 32'h0, hiBad);
    $display("done tests");
    wr(ADR_XCHG, 32'h1);
    chk(ADR_AF, 32'hffff, 32'h0, "alt af");
    chk(ADR_BC, 32'hffff, {r[0], r[1]}, "main bc");
    wr(ADR_XCHG, 32'h2);
    chk(ADR_BC, 32'hffff, 32'h0, "alt bc");
    wr(ADR_XCHG, 32'h3);
    chk(ADR_AF, 32'hff00, {r[7], 8'h00}, "back af");
    chk(ADR_BC, 32'hffff, {r[0], r[1]}, "back bc");
    $display("done exchange");
    wr(ADR_IR, 32'h5afe);
    repeat (3) begin
      fetchPulse <= 1'b1;
      @(posedge core_clk);
      fetchPulse <= 1'b0;
      @(posedge core_clk);
    end
    chk(ADR_IR, 32'hffff, 32'h5a81, "refresh");
    $display("done refresh");
    wr(ADR_CMD, {28'h0, OP_SLEEP});
    for (int i = 0; i < 20 && sleepMode !== 1'b1; i++) @(posedge core_clk);
    cmp("sleep", 32'h1, sleepMode);
    chk(ADR_STAT, 32'h200, 32'h200, "sleep stat");
    wakeReq <= 1'b1;
    @(posedge core_clk);
    wakeReq <= 1'b0;
    for (int i = 0; i < 20 && sleepMode !== 1'b0; i++) @(posedge core_clk);
    cmp("wake", 32'h0, sleepMode);
    $display("done sleep");
    give_verdict();
  end
endmodule : tb_extended_instruction_datapath
`default_nettype wire
